// File: rtl/octal_switch_spi.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Reset low clears shift register and turns every channel off.
// - Fault pin drops low once any channel has a latched error.
// - Faults are latched; a newer error overwrites the stored code.
// - Serial output is released while chip select is high.
// - With chip select low every diagnosis bit can be shifted out.
// - Chip select rising edge clears latched error codes, except on channels whose fault is still present.
// - Two diagnostic bits per channel in the output word.
// - Fault-free channel reports both bits high.
// - Current limit active reports high then low.
// - Open load reports low then high.
// - Short to ground reports both bits low.
// - Control byte zero means diagnosis only; outputs kept.
// - Any other control byte loads data, ANDed with parallel inputs 1-4.
// - New output state applied at chip select rising edge.
// - Frame is control byte then data byte, one bit per channel.
// - Frame accepted only with exactly sixteen clock pulses.
// - Input and output both shift most significant bit first.
// - Chip select falling edge loads diagnosis into shift register.
module octal_switch_spi (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic fault_n_o,
    output logic fault_n_oe_o,
    input wire logic input_polarity_select_i,
    input wire logic [3:0] parallel_channel_in_i,
    input wire logic [7:0] current_limit_i,
    input wire logic [7:0] open_load_i,
    input wire logic [7:0] short_gnd_i,
    output logic [7:0] power_channel_out_o
);
    diag_if dg ();

    logic [2:0] cs_sync_reg;
    logic [2:0] sclk_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] rstp_sync_reg;
    logic [1:0] pol_sync_reg;
    logic [3:0] par_a_reg;
    logic [3:0] par_b_reg;

    // Two-stage synchronisers; third stage only for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_sync_reg <= 3'h7;
            sclk_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
            rstp_sync_reg <= 2'h0;
            pol_sync_reg <= 2'h3;
            par_a_reg <= 4'h0;
            par_b_reg <= 4'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
            rstp_sync_reg <= {rstp_sync_reg[0], reset_pin_n_i};
            pol_sync_reg <= {pol_sync_reg[0], input_polarity_select_i};
            par_a_reg <= parallel_channel_in_i;
            par_b_reg <= par_a_reg;
        end
    end

    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;
    logic pin_reset;
    assign cs_low = !cs_sync_reg[1];
    assign cs_fall = cs_sync_reg[2] && !cs_sync_reg[1];
    assign cs_rise = !cs_sync_reg[2] && cs_sync_reg[1];
    assign sclk_fall = sclk_sync_reg[2] && !sclk_sync_reg[1];
    assign sclk_rise = !sclk_sync_reg[2] && sclk_sync_reg[1];
    assign pin_reset = !rstp_sync_reg[1];

    octal_switch_pkg::frame_state_t state_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [4:0] count_reg;
    logic [7:0] latch_reg;
    logic [7:0] out_reg;
    logic sdo_reg;
    logic sdo_oe_reg;
    logic fault_reg;
    logic clear_reg;

    // Frame sequencing follows chip select
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= octal_switch_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                octal_switch_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= octal_switch_pkg::ST_SHIFT;
                    end
                end
                octal_switch_pkg::ST_SHIFT: begin
                    if (cs_rise) begin
                        state_reg <= octal_switch_pkg::ST_DONE;
                    end
                end
                octal_switch_pkg::ST_DONE: begin
                    state_reg <= octal_switch_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= octal_switch_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Receive shifter and pulse counter; counter saturates at 31
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_reg <= 16'h0000;
            count_reg <= 5'h00;
        end else if (pin_reset) begin
            rx_reg <= 16'h0000;
            count_reg <= 5'h00;
        end else if (cs_fall) begin
            count_reg <= 5'h00;
        end else if (cs_low && sclk_fall) begin
            rx_reg <= {rx_reg[14:0], sdi_sync_reg[1]};
            if (count_reg != 5'h1f) begin
                count_reg <= count_reg + 5'h01;
            end
        end
    end

    // Transmit shifter: load on select, advance on clock rise
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_reg <= octal_switch_pkg::DIAG_RESET;
            sdo_reg <= 1'b1;
            sdo_oe_reg <= 1'b0;
        end else if (cs_fall) begin
            tx_reg <= {dg.word[14:0], 1'b1};
            sdo_reg <= dg.word[15];
            sdo_oe_reg <= 1'b1;
        end else if (!cs_low) begin
            sdo_oe_reg <= 1'b0;
        end else if (sclk_rise) begin
            sdo_reg <= tx_reg[15];
            tx_reg <= {tx_reg[14:0], 1'b1};
        end
    end

    // Output latch updated at frame end; control byte gates it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_reg <= octal_switch_pkg::OUTPUT_RESET;
        end else if (pin_reset) begin
            latch_reg <= octal_switch_pkg::OUTPUT_RESET;
        end else if (cs_rise && state_reg == octal_switch_pkg::ST_SHIFT
                     && count_reg == octal_switch_pkg::FRAME_COUNT
                     && rx_reg[15:8] != octal_switch_pkg::CTRL_DIAG_ONLY) begin
            // Diagnosis-only frames fall through and keep the outputs
            latch_reg <= rx_reg[7:0];
        end
    end

    logic [3:0] par_on;
    assign par_on = pol_sync_reg[1] ? par_b_reg : ~par_b_reg;

    // Parallel inputs can only veto, never force a channel on
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_reg <= octal_switch_pkg::OUTPUT_RESET;
        end else if (pin_reset) begin
            out_reg <= octal_switch_pkg::OUTPUT_RESET;
        end else begin
            out_reg <= {latch_reg[7:4], latch_reg[3:0] & par_on};
        end
    end

    // Clear pulse on select release; new faults still win inside
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= cs_rise;
        end
    end
    assign dg.clear = clear_reg;

    // Fault pin pulls low while any error is latched
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= dg.active;
        end
    end

    diag_latch u_diag (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .current_limit_i(current_limit_i),
        .open_load_i(open_load_i),
        .short_gnd_i(short_gnd_i),
        .dg(dg)
    );

    assign sdo_o = sdo_reg;
    assign sdo_oe_o = sdo_oe_reg;
    assign fault_n_o = 1'b0;
    assign fault_n_oe_o = fault_reg;
    assign power_channel_out_o = out_reg;

    a_sdo_release: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_sync_reg[1] && cs_sync_reg[2]) |=> !sdo_oe_reg)
        else $error("serial output driven while deselected");
    a_diag_only_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && rx_reg[15:8] == octal_switch_pkg::CTRL_DIAG_ONLY
         && !pin_reset)
        |=> $stable(latch_reg))
        else $error("diagnosis-only frame changed outputs");
    a_frame_count: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && count_reg != octal_switch_pkg::FRAME_COUNT && !pin_reset)
        |=> $stable(latch_reg))
        else $error("short frame accepted");
    a_frame_load: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && count_reg == octal_switch_pkg::FRAME_COUNT
         && rx_reg[15:8] != octal_switch_pkg::CTRL_DIAG_ONLY && !pin_reset)
        |=> latch_reg == $past(rx_reg[7:0]))
        else $error("valid frame not loaded");
    a_reset_off: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        pin_reset |=> out_reg == 8'h00 && rx_reg == 16'h0000)
        else $error("pin reset did not clear outputs");
    a_fault_flag: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        dg.active |=> fault_n_oe_o)
        else $error("fault pin not asserted");
    a_diag_load: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cs_fall |=> sdo_reg == $past(dg.word[15]) && sdo_oe_reg)
        else $error("diagnosis not loaded at select");
    a_par_and: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (!pin_reset && !latch_reg[0]) |=> !out_reg[0])
        else $error("parallel input forced channel on");
endmodule
`default_nettype wire

// File: include/octal_switch_pkg.sv
package octal_switch_pkg;
    localparam int unsigned CHANNELS = 8;
    localparam int unsigned FRAME_BITS = 16;
    localparam logic [4:0] FRAME_COUNT = 5'h10;
    localparam logic [7:0] CTRL_DIAG_ONLY = 8'h00;
    // Diagnostic pair codes, upper bit shifted first
    localparam logic [1:0] DIAG_OK = 2'h3;
    localparam logic [1:0] DIAG_CURRENT_LIMIT = 2'h2;
    localparam logic [1:0] DIAG_OPEN_LOAD = 2'h1;
    localparam logic [1:0] DIAG_SHORT_GND = 2'h0;
    localparam logic [7:0] OUTPUT_RESET = 8'h00;
    localparam logic [15:0] DIAG_RESET = 16'hffff;
    // Settle time the master waits before the read-back frame
    localparam int unsigned SETTLE_TIME_US = 150;
    localparam int unsigned SYS_CLK_MHZ = 25;
    localparam int unsigned SETTLE_CYCLES = SETTLE_TIME_US * SYS_CLK_MHZ;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b11
    } frame_state_t;
endpackage

// File: include/diag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
    logic [15:0] word;
    logic active;
    logic clear;
    modport latch (output word, output active, input clear);
    modport user (input word, input active, output clear);
endinterface
`default_nettype wire

// File: rtl/diag_latch.sv
`timescale 1ns/1ps
`default_nettype none
module diag_latch (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] current_limit_i,
    input wire logic [7:0] open_load_i,
    input wire logic [7:0] short_gnd_i,
    diag_if.latch dg
);
    logic [15:0] word_reg;
    logic [7:0] flt_a_reg;
    logic [7:0] flt_b_reg;
    logic [15:0] word_next;

    // Fault inputs are asynchronous analog status; resync first
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flt_a_reg <= 8'h00;
            flt_b_reg <= 8'h00;
        end else begin
            flt_a_reg <= current_limit_i;
            flt_b_reg <= flt_a_reg;
        end
    end

    logic [7:0] ol_a_reg, ol_b_reg, sg_a_reg, sg_b_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ol_a_reg <= 8'h00;
            ol_b_reg <= 8'h00;
            sg_a_reg <= 8'h00;
            sg_b_reg <= 8'h00;
        end else begin
            ol_a_reg <= open_load_i;
            ol_b_reg <= ol_a_reg;
            sg_a_reg <= short_gnd_i;
            sg_b_reg <= sg_a_reg;
        end
    end

    // Per channel pair; channel eight sits in the top pair
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_ch
            always_comb begin
                word_next[2*ch+1:2*ch] = word_reg[2*ch+1:2*ch];
                if (dg.clear) begin
                    word_next[2*ch+1:2*ch] = octal_switch_pkg::DIAG_OK;
                end
                // Active fault wins over the clear and overwrites older code
                if (sg_b_reg[ch]) begin
                    word_next[2*ch+1:2*ch] =
                        octal_switch_pkg::DIAG_SHORT_GND;
                end else if (ol_b_reg[ch]) begin
                    word_next[2*ch+1:2*ch] =
                        octal_switch_pkg::DIAG_OPEN_LOAD;
                end else if (flt_b_reg[ch]) begin
                    word_next[2*ch+1:2*ch] =
                        octal_switch_pkg::DIAG_CURRENT_LIMIT;
                end
            end
        end
    endgenerate

    // Latched diagnosis word
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_reg <= octal_switch_pkg::DIAG_RESET;
        end else begin
            word_reg <= word_next;
        end
    end

    assign dg.word = word_reg;
    assign dg.active = (word_reg != octal_switch_pkg::DIAG_RESET);

    a_fault_latched: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        sg_b_reg[0] |=> word_reg[1:0] == octal_switch_pkg::DIAG_SHORT_GND)
        else $error("short to ground not latched");
    a_clear_restores: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (dg.clear && !sg_b_reg[0] && !ol_b_reg[0] && !flt_b_reg[0])
        |=> word_reg[1:0] == octal_switch_pkg::DIAG_OK)
        else $error("clear did not restore normal code");
endmodule
`default_nettype wire

// File: testbench/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input wire logic sys_clk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    // One frame of n clocks; 4 sys clocks per phase, 320 ns link clock
    task automatic frame(input logic [15:0] tx, input int n,
                         output logic [15:0] rx, output logic oe_ok);
        rx = 16'h0000;
        oe_ok = 1'b1;
        @(negedge sys_clk_i);
        cs_n_o = 1'b0;
        sdi_o = tx[15];
        repeat (4) @(negedge sys_clk_i);
        for (int k = 0; k < n; k++) begin
            // Take the output bit just before the rise moves it on
            rx = {rx[14:0], sdo_i};
            oe_ok = oe_ok & sdo_oe_i;
            sclk_o = 1'b1;
            sdi_o = (k < 16) ? tx[15 - k] : ~sdi_o;
            repeat (4) @(negedge sys_clk_i);
            sclk_o = 1'b0;
            repeat (4) @(negedge sys_clk_i);
        end
        // Released data line shows the inverse, not a stale bit
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        repeat (4) @(negedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

// File: testbench/test_octal_switch_spi.sv
`timescale 1ns/1ps
`default_nettype none
module test_octal_switch_spi;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reset_pin_n = 1'b1;
    logic pol = 1'b1;
    logic [3:0] par = 4'hf;
    logic [7:0] cl = 8'h00;
    logic [7:0] ol = 8'h00;
    logic [7:0] sg = 8'h00;
    logic cs_n, sclk, sdi, sdo, sdo_oe, fault_n, fault_n_oe;
    logic [7:0] pout;
    wire logic fault_line = fault_n_oe ? fault_n : 1'b1;
    wire logic sdo_line = sdo_oe ? sdo : ~sdo;
    int err_count = 0;
    int n_tests = 0;
    logic [15:0] rx;
    logic ok;
    logic [7:0] ctrl, data, exp_out;
    logic [31:0] seed;

    always #20 sys_clk = ~sys_clk;

    octal_switch_spi u_octal_switch_spi (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .reset_pin_n_i(reset_pin_n),
        .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .fault_n_o(fault_n), .fault_n_oe_o(fault_n_oe),
        .input_polarity_select_i(pol), .parallel_channel_in_i(par),
        .current_limit_i(cl), .open_load_i(ol), .short_gnd_i(sg),
        .power_channel_out_o(pout)
    );

    spi_master_model u_spi_master_model (
        .sys_clk_i(sys_clk), .sdo_i(sdo_line), .sdo_oe_i(sdo_oe),
        .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Worst fault per channel wins; channel eight's pair goes first
    function automatic logic [15:0] diag_word(logic [7:0] l, logic [7:0] o,
                                              logic [7:0] s);
        logic [15:0] w;
        for (int c = 7; c >= 0; c--)
            w[2*c +: 2] = s[c] ? octal_switch_pkg::DIAG_SHORT_GND :
                          o[c] ? octal_switch_pkg::DIAG_OPEN_LOAD :
                          l[c] ? octal_switch_pkg::DIAG_CURRENT_LIMIT :
                          octal_switch_pkg::DIAG_OK;
        return w;
    endfunction

    // Command, settle, then the same frame again carries the diagnosis
    task automatic read_diag(input logic [15:0] tx, output logic [15:0] r);
        logic k;
        u_spi_master_model.frame(tx, 16, r, k);
        repeat (octal_switch_pkg::SETTLE_CYCLES) @(negedge sys_clk);
        u_spi_master_model.frame(tx, 16, r, k);
    endtask

    initial begin
        seed = $urandom(32'hbd74);
        repeat (10) @(negedge sys_clk);
        check(pout, 16'h0000);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({fault_line, sdo_oe}, 16'h0002);
        // Writes: corner control bytes, then random ones
        for (int i = 0; i < 10; i++) begin
            ctrl = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : $urandom;
            if (ctrl == 8'h00) ctrl = 8'h80;
            data = $urandom;
            pol = $urandom;
            par = $urandom;
            exp_out = {data[7:4], data[3:0] & (pol ? par : ~par)};
            u_spi_master_model.frame({ctrl, data}, 16, rx, ok);
            repeat (4) @(negedge sys_clk);
            check(pout, exp_out);
            check(ok, 1'b1);
            check(sdo_oe, 1'b0);
        end
        // Short and long frames are refused
        for (int n = 15; n <= 17; n += 2) begin
            u_spi_master_model.frame({8'hff, ~exp_out}, n, rx, ok);
            repeat (4) @(negedge sys_clk);
            check(pout, exp_out);
        end
        // Live faults, read back by diagnosis-only frames
        for (int j = 0; j < 5; j++) begin
            cl = (j == 0) ? 8'h00 : $urandom;
            ol = (j == 0) ? 8'h00 : $urandom;
            sg = (j == 0) ? 8'h00 : $urandom;
            repeat (10) @(negedge sys_clk);
            data = $urandom;
            read_diag({8'h00, data}, rx);
            check(rx, diag_word(cl, ol, sg));
            check(fault_line, diag_word(cl, ol, sg) == 16'hffff);
            check(pout, exp_out);
        end
        // Transient faults must stay latched until chip select rises
        cl = 8'h00;
        ol = 8'h00;
        sg = 8'h00;
        repeat (10) @(negedge sys_clk);
        u_spi_master_model.frame(16'h0000, 16, rx, ok);
        repeat (8) @(negedge sys_clk);
        check(fault_line, 1'b1);
        cl = 8'h20;
        ol = 8'h04;
        repeat (10) @(negedge sys_clk);
        cl = 8'h00;
        ol = 8'h00;
        sg = 8'h20;
        repeat (10) @(negedge sys_clk);
        sg = 8'h00;
        repeat (10) @(negedge sys_clk);
        check(fault_line, 1'b0);
        u_spi_master_model.frame(16'h0000, 16, rx, ok);
        check(rx, diag_word(8'h00, 8'h04, 8'h20));
        repeat (8) @(negedge sys_clk);
        check(fault_line, 1'b1);
        u_spi_master_model.frame(16'h0000, 16, rx, ok);
        check(rx, 16'hffff);
        // Reset pin switches every channel off
        reset_pin_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        check(pout, 16'h0000);
        reset_pin_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        summarize();
    end

    // Cuts a hang well past the expected run length
    initial begin
        #(60000 * 40);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
